// ---- pop_cfg.svh ----
// Offsets, field positions, reset values and counts of the overcurrent protection block.
`ifndef POP_CFG_SVH
`define POP_CFG_SVH
// Register word addresses.
`define POP_A_OCC1_THR 8'h00
`define POP_A_CHG_OVERCURRENT_TIER2_FLAG_THR 8'h01
`define POP_A_OCD1_THR 8'h02
`define POP_A_DSG_OVERCURRENT_TIER2_FLAG_THR 8'h03
`define POP_A_CHG_REC 8'h04
`define POP_A_DSG_REC 8'h05
`define POP_A_OCC1_TIME 8'h06
`define POP_A_CHG_OVERCURRENT_TIER2_FLAG_TIME 8'h07
`define POP_A_OCD1_TIME 8'h08
`define POP_A_DSG_OVERCURRENT_TIER2_FLAG_TIME 8'h09
`define POP_A_REC_TIME 8'h0A
`define POP_A_CFG 8'h0B
`define POP_A_ALERT 8'h0C
`define POP_A_STATUS 8'h0D
`define POP_A_AVG 8'h0E
`define POP_A_OPSTAT 8'h0F
// Fault bit positions in the status and non-removable words.
`define POP_F_OCD 0
`define POP_F_OCC 1
`define POP_F_DSG_OVERCURRENT_TIER2_FLAG 2
`define POP_F_CHG_OVERCURRENT_TIER2_FLAG 3
`define POP_F_FRONTEND_DSG_OVERCURRENT_FLAG 4
`define POP_F_SCD 5
`define POP_F_SCC 6
// Position of the non-removable pack bit in the configuration word.
`define POP_CFG_NR_POS 8
// Operation status word fields.
`define POP_OP_DISCHARGE_DISABLED_BIT 0
`define POP_OP_DISCHARGE_DISABLED_BY_CURRENT_BIT 1
`define POP_OP_TCA 2
`define POP_OP_CHG_EN 3
`define POP_OP_DSG_EN 4
`define POP_OP_ZERO_I 5
`define POP_OP_ZERO_V 6
// Reset values.
`define POP_RST_OCC1_THR 16'h1770
`define POP_RST_CHG_OVERCURRENT_TIER2_FLAG_THR 16'h1F40
`define POP_RST_OCD1_THR 16'hE890
`define POP_RST_DSG_OVERCURRENT_TIER2_FLAG_THR 16'hE0C0
`define POP_RST_CHG_REC 16'h00C8
`define POP_RST_DSG_REC 16'hFF38
`define POP_RST_BUF_TIME 8'h02
`define POP_RST_REC_TIME 8'h08
`define POP_RST_NR_CFG 7'h00
// Averaging weight as a right shift per one-second update.
`define POP_AVG_SHIFT 2
`endif

// ---- pop_pkg.sv ----
// Types shared by the overcurrent protection block.
package pop_pkg;
  typedef logic signed [15:0] pop_cur_t;
  typedef logic [7:0] pop_sec_t;
  typedef logic [6:0] pop_faults_t;

  // State of one buffer timer.
  typedef struct packed {
    logic alert;
    logic expire;
    pop_sec_t cnt;
  } pop_tmr_state_t;

  // Software-written settings.
  typedef struct packed {
    pop_cur_t occ1_thr;
    pop_cur_t chg_overcurrent_tier2_flag_thr;
    pop_cur_t ocd1_thr;
    pop_cur_t dsg_overcurrent_tier2_flag_thr;
    pop_cur_t chg_rec;
    pop_cur_t dsg_rec;
    pop_sec_t occ1_time;
    pop_sec_t chg_overcurrent_tier2_flag_time;
    pop_sec_t ocd1_time;
    pop_sec_t dsg_overcurrent_tier2_flag_time;
    pop_sec_t rec_time;
    logic non_removable_pack_bit;
    pop_faults_t nr_cfg;
  } pop_regs_t;

  // Driven protection outputs.
  typedef struct packed {
    logic chg_fet_en;
    logic dsg_fet_en;
    logic discharge_disabled_bit;
    logic discharge_disabled_by_current_bit;
    logic terminate_charge_alarm_bit;
    logic chg_current_zero;
    logic chg_voltage_zero;
  } pop_outs_t;

  // State of the protection top outside its buffer timers.
  typedef struct packed {
    pop_regs_t regs;
    pop_cur_t avg;
    pop_faults_t status;
    pop_sec_t rec_cnt;
    logic [2:0] sync1;
    logic [2:0] sync2;
    pop_outs_t outs;
    logic [15:0] rdata;
  } pop_state_t;
endpackage

// ---- pop_fault_timer.sv ----
// Buffer timer that turns a persisting fault condition into an alert and an expiry pulse.
`timescale 1ns/1ps
`default_nettype none
module pop_fault_timer
  import pop_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // One-second tick, fault condition and programmed hold time.
  input wire logic tick,
  input wire logic cond,
  input wire pop_pkg::pop_sec_t hold_time,
  // Alert level and one-cycle expiry pulse.
  output logic alert,
  output logic expire
);
  import pop_pkg::*;

  pop_tmr_state_t s_r;
  pop_tmr_state_t s_nxt;

  // Alert starts the count afresh, ticks advance it, a lost condition or zero time clears it.
  always_comb
  begin
    pop_sec_t cnt_inc;
    cnt_inc = s_r.cnt + 8'h01;
    s_nxt = s_r;
    s_nxt.expire = 1'b0;
    if (hold_time == 8'h00 || !cond)
    begin
      s_nxt.alert = 1'b0;
      s_nxt.cnt = 8'h00;
    end
    else if (!s_r.alert)
    begin
      s_nxt.alert = 1'b1;
      s_nxt.cnt = 8'h00;
    end
    else if (tick && s_r.cnt != hold_time)
    begin
      s_nxt.cnt = cnt_inc;
      s_nxt.expire = (cnt_inc == hold_time);
    end
  end

  // State register.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign alert = s_r.alert;
  assign expire = s_r.expire;

  // A new alert always starts from a cleared count.
  chk_alert_restart: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(s_r.alert) |-> s_r.cnt == 8'h00) else $error("alert did not restart timer");
  // A zero hold time keeps the protection silent.
  chk_zero_disable: assert property (@(posedge ref_clk) disable iff (rst)
    hold_time == 8'h00 |=> !s_r.alert || $past(hold_time) != 8'h00)
    else $error("zero hold time raised alert");
  // Expiry only follows a tick with the alert standing.
  chk_expire_cause: assert property (@(posedge ref_clk) disable iff (rst)
    s_r.expire |-> $past(tick) && $past(s_r.alert) && s_r.cnt == hold_time)
    else $error("expiry without cause");
endmodule
`default_nettype wire

// ---- pop_protect.sv ----
// Two-tier pack overcurrent protection with current-based recovery and register port.
//
// Behaviour
// - Discharge current at or below tier-one threshold raises its alert and timer.
// - Tier-one discharge expiry latches fault, opens discharge, inhibits, zeroes charge current.
// - Tier-one discharge timer restarts on new alert, clears early, zero time disables.
// - Charge current at or above tier-two threshold raises its alert and timer.
// - Tier-two charge expiry latches, opens charge, alarms, zeroes charge current and voltage.
// - Tier-two charge timer restarts on new alert, clears early, zero time disables.
// - Discharge current at or below tier-two threshold raises its alert and timer.
// - Tier-two discharge expiry latches, opens discharge, inhibits, zeroes charge current.
// - Tier-two discharge timer restarts on new alert, clears early, zero time disables.
// - Charge faults clear after average stays below charge recovery for recovery time.
// - Discharge faults clear after average stays above discharge recovery for recovery time.
// - Recovery enabled by non-removable bit, else per-fault enable bits.
// - Recovery waits for the recovery timer before clearing and re-enabling switches.
// - One recovery timer serves seven overcurrent and short-circuit faults.
// - Average current is recomputed once per second from the measured current.
// - Discharge currents and thresholds are negative signed values.
// - Charge current at or above tier-one threshold alerts, then latches and opens charge.
// - Tier-one charge timer restarts on new alert, clears early, zero time disables.
`include "pop_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pop_protect
  import pop_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Measurement from the front end, same clock domain.
  input wire logic meas_tick,
  input wire pop_pkg::pop_cur_t meas_current,
  // Front-end fault pins, asynchronous.
  input wire logic frontend_dsg_overcurrent_flag,
  input wire logic frontend_dsg_short_flag,
  input wire logic frontend_chg_short_flag,
  // Alert and latched fault words.
  output logic [3:0] safety_alert,
  output pop_pkg::pop_faults_t safety_status,
  // Switch and charger controls.
  output logic chg_fet_en,
  output logic dsg_fet_en,
  output logic discharge_disabled_bit,
  output logic discharge_disabled_by_current_bit,
  output logic terminate_charge_alarm_bit,
  output logic chg_current_zero,
  output logic chg_voltage_zero
);
  import pop_pkg::*;

  // Fault groups by direction.
  localparam pop_faults_t CHG_MASK = pop_faults_t'((1 << `POP_F_OCC) | (1 << `POP_F_CHG_OVERCURRENT_TIER2_FLAG) |
                                                   (1 << `POP_F_SCC));
  localparam pop_faults_t DSG_MASK = pop_faults_t'((1 << `POP_F_OCD) | (1 << `POP_F_DSG_OVERCURRENT_TIER2_FLAG) |
                                                   (1 << `POP_F_FRONTEND_DSG_OVERCURRENT_FLAG) | (1 << `POP_F_SCD));

  pop_state_t s_r;
  pop_state_t s_nxt;
  logic [3:0] cond;
  logic [3:0] alert;
  logic [3:0] expire;
  pop_sec_t hold [4];

  // Returns true when the word address matches a register.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Fault conditions; zero current is neither charging nor discharging.
  always_comb
  begin
    cond = 4'h0;
    cond[0] = meas_current < 0 && meas_current <= s_r.regs.ocd1_thr;
    cond[1] = meas_current > 0 && meas_current >= s_r.regs.occ1_thr;
    cond[2] = meas_current < 0 && meas_current <= s_r.regs.dsg_overcurrent_tier2_flag_thr;
    cond[3] = meas_current > 0 && meas_current >= s_r.regs.chg_overcurrent_tier2_flag_thr;
  end

  assign hold[0] = s_r.regs.ocd1_time;
  assign hold[1] = s_r.regs.occ1_time;
  assign hold[2] = s_r.regs.dsg_overcurrent_tier2_flag_time;
  assign hold[3] = s_r.regs.chg_overcurrent_tier2_flag_time;

  // One independent buffer timer per slow protection, index matching the fault bit.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_tmr
      pop_fault_timer u_tmr (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(meas_tick),
        .cond(cond[gi]),
        .hold_time(hold[gi]),
        .alert(alert[gi]),
        .expire(expire[gi])
      );
    end
  endgenerate

  // Next state: settings, averaging, fault latch, recovery and read data.
  always_comb
  begin
    logic signed [16:0] diff;
    logic signed [16:0] step;
    pop_faults_t rec_ok;
    pop_faults_t rec_en;
    pop_faults_t sets;
    pop_sec_t rec_inc;
    logic rec_active;
    diff = 17'(meas_current) - 17'(s_r.avg);
    step = diff >>> `POP_AVG_SHIFT;
    rec_inc = s_r.rec_cnt + 8'h01;
    s_nxt = s_r;
    s_nxt.rdata = 16'h0000;
    // Front-end pins pass two flip-flops before use.
    s_nxt.sync1 = {frontend_chg_short_flag, frontend_dsg_short_flag,
                   frontend_dsg_overcurrent_flag};
    s_nxt.sync2 = s_r.sync1;
    // Register writes.
    if (reg_wr)
    begin
      if (hit(reg_addr, `POP_A_OCC1_THR))
        s_nxt.regs.occ1_thr = reg_wdata;
      if (hit(reg_addr, `POP_A_CHG_OVERCURRENT_TIER2_FLAG_THR))
        s_nxt.regs.chg_overcurrent_tier2_flag_thr = reg_wdata;
      if (hit(reg_addr, `POP_A_OCD1_THR))
        s_nxt.regs.ocd1_thr = reg_wdata;
      if (hit(reg_addr, `POP_A_DSG_OVERCURRENT_TIER2_FLAG_THR))
        s_nxt.regs.dsg_overcurrent_tier2_flag_thr = reg_wdata;
      if (hit(reg_addr, `POP_A_CHG_REC))
        s_nxt.regs.chg_rec = reg_wdata;
      if (hit(reg_addr, `POP_A_DSG_REC))
        s_nxt.regs.dsg_rec = reg_wdata;
      if (hit(reg_addr, `POP_A_OCC1_TIME))
        s_nxt.regs.occ1_time = reg_wdata[7:0];
      if (hit(reg_addr, `POP_A_CHG_OVERCURRENT_TIER2_FLAG_TIME))
        s_nxt.regs.chg_overcurrent_tier2_flag_time = reg_wdata[7:0];
      if (hit(reg_addr, `POP_A_OCD1_TIME))
        s_nxt.regs.ocd1_time = reg_wdata[7:0];
      if (hit(reg_addr, `POP_A_DSG_OVERCURRENT_TIER2_FLAG_TIME))
        s_nxt.regs.dsg_overcurrent_tier2_flag_time = reg_wdata[7:0];
      if (hit(reg_addr, `POP_A_REC_TIME))
        s_nxt.regs.rec_time = reg_wdata[7:0];
      if (hit(reg_addr, `POP_A_CFG))
      begin
        s_nxt.regs.nr_cfg = reg_wdata[6:0];
        s_nxt.regs.non_removable_pack_bit = reg_wdata[`POP_CFG_NR_POS];
      end
    end
    // Average current moves toward the sample once per second.
    if (meas_tick)
      s_nxt.avg = 16'(17'(s_r.avg) + step);
    // Recovery condition per fault against the averaged current.
    for (int i = 0; i < 7; i++)
    begin
      rec_ok[i] = CHG_MASK[i] ? (s_r.avg < s_r.regs.chg_rec)
                              : (s_r.avg > s_r.regs.dsg_rec);
    end
    rec_en = s_r.regs.non_removable_pack_bit ? 7'h7F : s_r.regs.nr_cfg;
    rec_ok = rec_ok & rec_en & s_r.status;
    rec_active = (rec_ok != 7'h00);
    // Shared recovery timer; faults clear only at its expiry.
    if (!rec_active)
      s_nxt.rec_cnt = 8'h00;
    else if (meas_tick)
    begin
      if (rec_inc >= s_r.regs.rec_time)
      begin
        s_nxt.status = s_r.status & ~rec_ok;
        s_nxt.rec_cnt = 8'h00;
      end
      else
        s_nxt.rec_cnt = rec_inc;
    end
    // New faults win over a recovery in the same cycle.
    sets = 7'h00;
    sets[`POP_F_OCD] = expire[0];
    sets[`POP_F_OCC] = expire[1];
    sets[`POP_F_DSG_OVERCURRENT_TIER2_FLAG] = expire[2];
    sets[`POP_F_CHG_OVERCURRENT_TIER2_FLAG] = expire[3];
    sets[`POP_F_FRONTEND_DSG_OVERCURRENT_FLAG] = s_r.sync2[0];
    sets[`POP_F_SCD] = s_r.sync2[1];
    sets[`POP_F_SCC] = s_r.sync2[2];
    s_nxt.status = s_nxt.status | sets;
    // Switch and charger controls follow the latched faults.
    s_nxt.outs.chg_fet_en = !(|(s_nxt.status & CHG_MASK));
    s_nxt.outs.dsg_fet_en = !(|(s_nxt.status & DSG_MASK));
    s_nxt.outs.discharge_disabled_bit = |(s_nxt.status & DSG_MASK);
    s_nxt.outs.discharge_disabled_by_current_bit = |(s_nxt.status & DSG_MASK);
    s_nxt.outs.terminate_charge_alarm_bit = |(s_nxt.status & CHG_MASK);
    s_nxt.outs.chg_current_zero = |s_nxt.status;
    s_nxt.outs.chg_voltage_zero = |(s_nxt.status & CHG_MASK);
    // Register reads answer in the next cycle only; unmapped reads give zero.
    if (reg_rd)
    begin
      unique case (reg_addr)
        `POP_A_OCC1_THR: s_nxt.rdata = s_r.regs.occ1_thr;
        `POP_A_CHG_OVERCURRENT_TIER2_FLAG_THR: s_nxt.rdata = s_r.regs.chg_overcurrent_tier2_flag_thr;
        `POP_A_OCD1_THR: s_nxt.rdata = s_r.regs.ocd1_thr;
        `POP_A_DSG_OVERCURRENT_TIER2_FLAG_THR: s_nxt.rdata = s_r.regs.dsg_overcurrent_tier2_flag_thr;
        `POP_A_CHG_REC: s_nxt.rdata = s_r.regs.chg_rec;
        `POP_A_DSG_REC: s_nxt.rdata = s_r.regs.dsg_rec;
        `POP_A_OCC1_TIME: s_nxt.rdata = {8'h00, s_r.regs.occ1_time};
        `POP_A_CHG_OVERCURRENT_TIER2_FLAG_TIME: s_nxt.rdata = {8'h00, s_r.regs.chg_overcurrent_tier2_flag_time};
        `POP_A_OCD1_TIME: s_nxt.rdata = {8'h00, s_r.regs.ocd1_time};
        `POP_A_DSG_OVERCURRENT_TIER2_FLAG_TIME: s_nxt.rdata = {8'h00, s_r.regs.dsg_overcurrent_tier2_flag_time};
        `POP_A_REC_TIME: s_nxt.rdata = {8'h00, s_r.regs.rec_time};
        `POP_A_CFG: s_nxt.rdata = {7'h00, s_r.regs.non_removable_pack_bit, 1'b0,
                                   s_r.regs.nr_cfg};
        `POP_A_ALERT: s_nxt.rdata = {12'h000, alert[3], alert[2], alert[1], alert[0]};
        `POP_A_STATUS: s_nxt.rdata = {9'h000, s_r.status};
        `POP_A_AVG: s_nxt.rdata = s_r.avg;
        `POP_A_OPSTAT: s_nxt.rdata = {9'h000, s_r.outs.chg_voltage_zero,
                                      s_r.outs.chg_current_zero, s_r.outs.dsg_fet_en,
                                      s_r.outs.chg_fet_en,
                                      s_r.outs.terminate_charge_alarm_bit,
                                      s_r.outs.discharge_disabled_by_current_bit,
                                      s_r.outs.discharge_disabled_bit};
        default: s_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // State register with documented settings and both switches enabled at reset.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.regs.occ1_thr <= `POP_RST_OCC1_THR;
      s_r.regs.chg_overcurrent_tier2_flag_thr <= `POP_RST_CHG_OVERCURRENT_TIER2_FLAG_THR;
      s_r.regs.ocd1_thr <= `POP_RST_OCD1_THR;
      s_r.regs.dsg_overcurrent_tier2_flag_thr <= `POP_RST_DSG_OVERCURRENT_TIER2_FLAG_THR;
      s_r.regs.chg_rec <= `POP_RST_CHG_REC;
      s_r.regs.dsg_rec <= `POP_RST_DSG_REC;
      s_r.regs.occ1_time <= `POP_RST_BUF_TIME;
      s_r.regs.chg_overcurrent_tier2_flag_time <= `POP_RST_BUF_TIME;
      s_r.regs.ocd1_time <= `POP_RST_BUF_TIME;
      s_r.regs.dsg_overcurrent_tier2_flag_time <= `POP_RST_BUF_TIME;
      s_r.regs.rec_time <= `POP_RST_REC_TIME;
      s_r.regs.nr_cfg <= `POP_RST_NR_CFG;
      s_r.outs.chg_fet_en <= 1'b1;
      s_r.outs.dsg_fet_en <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs come straight from the state register, the alert word from the timer registers.
  assign reg_rdata = s_r.rdata;
  assign safety_alert = alert;
  assign safety_status = s_r.status;
  assign chg_fet_en = s_r.outs.chg_fet_en;
  assign dsg_fet_en = s_r.outs.dsg_fet_en;
  assign discharge_disabled_bit = s_r.outs.discharge_disabled_bit;
  assign discharge_disabled_by_current_bit = s_r.outs.discharge_disabled_by_current_bit;
  assign terminate_charge_alarm_bit = s_r.outs.terminate_charge_alarm_bit;
  assign chg_current_zero = s_r.outs.chg_current_zero;
  assign chg_voltage_zero = s_r.outs.chg_voltage_zero;

  // Tier-one discharge expiry latches the fault one cycle later.
  chk_ocd1_latch: assert property (@(posedge ref_clk) disable iff (rst)
    expire[0] |=> s_r.status[`POP_F_OCD] && !s_r.outs.dsg_fet_en && s_r.outs.chg_current_zero)
    else $error("tier one discharge not latched");
  // Tier-two charge expiry opens charge and zeroes voltage.
  chk_chg_overcurrent_tier2_flag_latch: assert property (@(posedge ref_clk) disable iff (rst)
    expire[3] |=> s_r.status[`POP_F_CHG_OVERCURRENT_TIER2_FLAG] && !s_r.outs.chg_fet_en && s_r.outs.chg_voltage_zero)
    else $error("tier two charge not latched");
  // Tier-two discharge expiry sets both inhibit bits.
  chk_dsg_overcurrent_tier2_flag_inhibit: assert property (@(posedge ref_clk) disable iff (rst)
    expire[2] |=> s_r.outs.discharge_disabled_bit && s_r.outs.discharge_disabled_by_current_bit)
    else $error("tier two discharge inhibit missing");
  // Tier-one charge expiry raises the terminate-charge alarm.
  chk_occ1_alarm: assert property (@(posedge ref_clk) disable iff (rst)
    expire[1] |=> s_r.outs.terminate_charge_alarm_bit && !s_r.outs.chg_fet_en)
    else $error("tier one charge alarm missing");
  // A discharge alert only rises for a negative current.
  chk_dsg_signed: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(alert[0]) |-> $past(meas_current) < 0) else $error("discharge alert on charge");
  // The average changes only on a tick.
  chk_avg_tick: assert property (@(posedge ref_clk) disable iff (rst)
    !meas_tick |=> $stable(s_r.avg)) else $error("average moved without tick");
  // A fault clears only at a tick with the recovery timer at its end.
  chk_rec_timed: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(s_r.status[`POP_F_OCC]) |-> $past(meas_tick) &&
      ($past(s_r.rec_cnt) + 9'h001 >= {1'b0, $past(s_r.regs.rec_time)}))
    else $error("fault cleared before recovery time");
  // Recovery is refused for a removable pack without the enable bit.
  chk_rec_enable: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(s_r.status[`POP_F_OCD]) |->
      $past(s_r.regs.non_removable_pack_bit) || $past(s_r.regs.nr_cfg[`POP_F_OCD]))
    else $error("recovery without enable");
  // Read data stand only in the cycle after a read.
  chk_rdata_slot: assert property (@(posedge ref_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 16'h0000) else $error("read data outside slot");
endmodule
`default_nettype wire

// ---- pop_afe_model.sv ----
// Front-end model that delivers measurement ticks, the measured current and fault pins.
`timescale 1ns/1ps
`default_nettype none
module pop_afe_model
  import pop_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Requests from the bench.
  input wire logic [7:0] tick_per,
  input wire pop_pkg::pop_cur_t cur_req,
  input wire logic [2:0] fe_req,
  // Pins toward the protection block.
  output logic meas_tick,
  output pop_pkg::pop_cur_t meas_current,
  output logic [2:0] fe_pins
);
  logic [7:0] cnt_r;

  // One tick every tick_per plus one cycles; current and pins follow one cycle late.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 8'h00;
      meas_tick <= 1'b0;
      meas_current <= 16'sh0000;
      fe_pins <= 3'h0;
    end
    else
    begin
      cnt_r <= (cnt_r >= tick_per) ? 8'h00 : cnt_r + 8'h01;
      meas_tick <= (cnt_r == tick_per);
      meas_current <= cur_req;
      fe_pins <= fe_req;
    end
  end
endmodule
`default_nettype wire

// ---- pop_protect_tb_top.sv ----
// Self-checking bench of the overcurrent protection block with its front-end model.
`timescale 1ns/1ps
`default_nettype none
module pop_protect_tb_top;
  import pop_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic meas_tick;
  pop_cur_t meas_current;
  logic [2:0] fe_pins;
  logic [7:0] tick_per = 8'h09;
  pop_cur_t cur_req = 16'sh0000;
  logic [2:0] fe_req = 3'h0;
  logic [3:0] safety_alert;
  pop_faults_t safety_status;
  logic [6:0] outs;
  pop_cur_t avg_m;
  pop_cur_t avg_snap;
  logic [15:0] rd_v;
  int errors = 0;
  int samples_checked = 0;
  logic [15:0] rst_t [12] = '{16'h1770, 16'h1F40, 16'hE890, 16'hE0C0, 16'h00C8, 16'hFF38,
    16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h0008, 16'h0000};
  int tix [4] = '{2, 0, 3, 1};
  logic [3:0] am_t [4] = '{4'h1, 4'h2, 4'h5, 4'hA};
  logic [6:0] sm_t [4] = '{7'h01, 7'h02, 7'h05, 7'h0A};

  // Clock with a 20 ns period.
  always #10 ref_clk = ~ref_clk;

  // Reference average, refreshed on each tick.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      avg_m <= 16'sh0000;
    else if (meas_tick)
      avg_m <= avg_m + ((meas_current - avg_m) >>> 2);
  end

  pop_afe_model u_pop_afe_model (.ref_clk(ref_clk), .rst(rst), .tick_per(tick_per),
    .cur_req(cur_req), .fe_req(fe_req), .meas_tick(meas_tick), .meas_current(meas_current),
    .fe_pins(fe_pins));

  pop_protect u_pop_protect (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .meas_tick(meas_tick), .meas_current(meas_current),
    .frontend_dsg_overcurrent_flag(fe_pins[0]), .frontend_dsg_short_flag(fe_pins[1]),
    .frontend_chg_short_flag(fe_pins[2]), .safety_alert(safety_alert),
    .safety_status(safety_status), .chg_fet_en(outs[6]), .dsg_fet_en(outs[5]),
    .discharge_disabled_bit(outs[4]), .discharge_disabled_by_current_bit(outs[3]),
    .terminate_charge_alarm_bit(outs[2]), .chg_current_zero(outs[1]),
    .chg_voltage_zero(outs[0]));

  // ********************************
  // Checking and bus tasks
  // ********************************

  // Expected switch and charger controls for a latched fault word.
  function automatic logic [6:0] exp_outs(input logic [6:0] s);
    logic d;
    logic c;
  begin
    d = s[0] | s[2] | s[4] | s[5];
    c = s[1] | s[3] | s[6];
    return {~c, ~d, d, d, c, |s, c};
  end
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
  begin
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  task automatic end_sim;
  begin
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  task automatic tmo(input string what);
  begin
    errors++;
    $display("BAD %s expected done seen timeout", what);
    end_sim;
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
  begin
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  end
  endtask

  // Read strobe for one cycle; the average is captured at the edge that takes the read.
  task automatic rd(input logic [7:0] a);
  begin
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    avg_snap = avg_m;
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_v = reg_rdata;
    @(posedge ref_clk);
  end
  endtask

  // Called at a rising edge; returns at the falling edge where the alert shows.
  task automatic wait_alert(input logic [3:0] m);
  begin
    for (int k = 0; k < 8 && safety_alert === 4'h0; k++)
      @(negedge ref_clk);
    if (safety_alert === 4'h0)
      tmo("alert");
    chk("alert", {12'h000, safety_alert}, {12'h000, m});
  end
  endtask

  // Called at a falling edge; returns at the rising edge that takes the n-th tick.
  task automatic ticks(input int n);
    int seen;
  begin
    seen = 0;
    for (int k = 0; k < 4000 && seen < n; k++)
    begin
      if (meas_tick)
        seen++;
      if (seen < n)
        @(negedge ref_clk);
    end
    if (seen < n)
      tmo("tick");
    @(posedge ref_clk);
  end
  endtask

  // Zero current, then expect the faults in m to clear (clr) or to stay latched.
  task automatic recover(input logic [6:0] m, input int lim, input logic clr);
    int n;
  begin
    n = 0;
    cur_req <= 16'sh0000;
    for (int k = 0; k < lim && (safety_status & m) !== 7'h00; k++)
    begin
      @(negedge ref_clk);
      if (meas_tick)
        n++;
    end
    if (clr && (safety_status & m) !== 7'h00)
      tmo("recovery");
    chk("rec_status", {9'h000, safety_status}, clr ? 16'h0000 : {9'h000, m});
    chk("rec_outs", {9'h000, outs}, {9'h000, exp_outs(clr ? 7'h00 : m)});
    if (clr)
      chk("rec_ticks", {15'h0000, n >= 8}, 16'h0001);
    @(posedge ref_clk);
  end
  endtask

  // Reset, register map, every fault kind latched and recovered, early clears for the four timed faults.
  initial
  begin
    pop_cur_t cur;
    int t;
    void'($urandom(56468));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("reset_state", {5'h00, safety_alert, safety_status}, 16'h0000);
    chk("reset_outs", {9'h000, outs}, {9'h000, exp_outs(7'h00)});
    @(posedge ref_clk);
    for (int a = 0; a < 12; a++)
    begin
      rd(a[7:0]);
      chk("reset_reg", rd_v, rst_t[a]);
    end
    wr(8'h0D, 16'h007F);
    rd(8'h0D);
    chk("ro_status", rd_v, 16'h0000);
    rd(8'h20);
    chk("unmapped", rd_v, 16'h0000);
    for (int it = 0; it < 3; it++)
      for (int c = 0; c < 4; c++)
      begin
        t = 2 + $urandom % 2;
        tick_per <= 8'(5 + $urandom % 16);
        for (int a = 6; a < 10; a++)
          wr(a[7:0], 16'(t));
        cur = (it == 0) ? 16'sh0000 : pop_cur_t'($urandom % 1000);
        cur = c[0] ? rst_t[tix[c]] + cur : rst_t[tix[c]] - cur;
        if (it == 0 && c < 2)
        begin
          cur_req <= c[0] ? cur - 16'sh0001 : cur + 16'sh0001;
          repeat (4) @(negedge ref_clk);
          chk("edge_alert", {12'h000, safety_alert}, 16'h0000);
          @(posedge ref_clk);
        end
        cur_req <= cur;
        wait_alert(am_t[c]);
        ticks(t - 1);
        cur_req <= 16'sh0000;
        repeat (4) @(negedge ref_clk);
        chk("early_alert", {12'h000, safety_alert}, 16'h0000);
        chk("early_status", {9'h000, safety_status}, 16'h0000);
        @(posedge ref_clk);
        cur_req <= cur;
        wait_alert(am_t[c]);
        ticks(t);
        @(negedge ref_clk);
        chk("latch_soon", {9'h000, safety_status}, 16'h0000);
        @(negedge ref_clk);
        chk("latch", {9'h000, safety_status}, {9'h000, sm_t[c]});
        chk("latch_outs", {9'h000, outs}, {9'h000, exp_outs(sm_t[c])});
        @(posedge ref_clk);
        if (it == 0 && c == 0)
        begin
          recover(sm_t[c], 600, 1'b0);
          wr(8'h0B, 16'h0001);
        end
        else if (it == 0 && c == 1)
          wr(8'h0B, 16'h0100);
        recover(sm_t[c], 4000, 1'b1);
        rd(8'h0E);
        chk("average", rd_v, avg_snap);
      end
    for (int a = 6; a < 10; a++)
      wr(a[7:0], 16'h0000);
    for (int c = 0; c < 4; c++)
    begin
      cur_req <= rst_t[tix[c]];
      repeat (40) @(negedge ref_clk);
      chk("off_status", {9'h000, safety_status}, 16'h0000);
      @(posedge ref_clk);
    end
    for (int f = 0; f < 3; f++)
    begin
      fe_req <= 3'(1 << f);
      repeat (6) @(negedge ref_clk);
      chk("fe_status", {9'h000, safety_status}, {9'h000, 7'(7'h10 << f)});
      chk("fe_outs", {9'h000, outs}, {9'h000, exp_outs(7'(7'h10 << f))});
      @(posedge ref_clk);
      fe_req <= 3'h0;
      recover(7'(7'h10 << f), 4000, 1'b1);
    end
    end_sim;
  end
endmodule
`default_nettype wire
